// File: rtl/sfe_ctrl.sv
// Purpose: device-side decode of erase, sleep and wake/ID commands.
// Assumes: single-bit serial framing, mode 0 or 3; the array and its
//          self-timed erase engine sit outside and report done.
// Notes:   protection inputs are live levels from the status logic.
`timescale 1ns/1ps
`default_nettype none
module sfe_ctrl #(
    parameter logic [7:0] DEVICE_ID = 8'h5A  // arbitrary value
) (
    input  wire logic           clk_i,           // 40 MHz clock
    input  wire logic           sys_rst_i,       // async reset, high
    input  wire logic           sck_i,           // serial clock pin
    input  wire logic           cs_n_i,          // select pin, low active
    input  wire logic           serial_in_i,     // serial data in pin
    output logic                serial_out_o,    // serial data out
    output logic                serial_out_oe_o, // data out enable
    input  wire logic [3:0]     protect_level_bits_i, // block protect
    input  wire logic           whole_lock_bit_i, // whole-array lock
    input  wire logic           boot_lock_i,     // boot region lock
    input  wire logic [7:0]     boot_block_i,    // locked 64K block
    input  wire logic           erase_done_i,    // array erase finished
    output var sfe_pkg::sfe_erase_req_t erase_req_o, // erase request
    output logic                busy_flag_o,     // busy, status S0
    output logic                write_latch_flag_o, // latch, status S1
    output logic                asleep_o         // in deep power-down
);
    logic       rise, fall, cs_n, cs_rise, din;
    logic [5:0] bits_r;
    logic [7:0] op_r;
    localparam int ADDR_LEN = sfe_pkg::ADDR_W;
    logic [ADDR_LEN-1:0] addr_r;
    logic [7:0] out_r;
    logic [2:0] out_cnt_r;
    logic       oe_r;
    logic       latch_r;
    logic [sfe_pkg::TIMER_W-1:0] tmr_r;
    logic [sfe_pkg::TIMER_W-1:0] tmr_nxt;
    sfe_pkg::sfe_state_t st_r;
    sfe_pkg::sfe_state_t st_nxt;
    sfe_pkg::sfe_erase_req_t req_r;
    sfe_pkg::sfe_erase_req_t req_nxt;

    sfe_pin_sync u_sync (
        .clk_i       (clk_i),
        .sys_rst_i   (sys_rst_i),
        .sck_i       (sck_i),
        .cs_n_i      (cs_n_i),
        .serial_in_i (serial_in_i),
        .rise_o      (rise),
        .fall_o      (fall),
        .cs_n_o      (cs_n),
        .cs_rise_o   (cs_rise),
        .din_o       (din)
    );

    // frame decode terms
    wire [7:0] op_now    = {op_r[6:0], din};
    wire       is_addr_er = op_r == sfe_pkg::OP_HALF_ERASE ||
                            op_r == sfe_pkg::OP_BLOCK_ERASE;
    wire       is_chip_er = op_r == sfe_pkg::OP_CHIP_ERASE1 ||
                            op_r == sfe_pkg::OP_CHIP_ERASE2;
    wire       f_op8     = bits_r == sfe_pkg::BITS_OPCODE;
    wire       f_addr    = bits_r == sfe_pkg::BITS_ADDR_CMD;
    wire       standby   = st_r == sfe_pkg::SFE_STANDBY;
    wire       asleep    = st_r == sfe_pkg::SFE_ASLEEP;
    wire [7:0] tgt_blk   = addr_r[sfe_pkg::BLK_MSB:sfe_pkg::BLK_LSB];
    // protect level n (1 to 7) guards the top 2^n 64K blocks, level 0 none, bit 3 guards all; simple top-down map
    wire [8:0] prot_lim  = 9'h100 - (9'h001 << protect_level_bits_i[2:0]);
    wire       any_prot  = protect_level_bits_i != 4'h0;
    wire       blk_prot  = (any_prot && ({1'b0, tgt_blk} >= prot_lim ||
                            protect_level_bits_i[3])) ||
                           (boot_lock_i && tgt_blk == boot_block_i);
    wire       chip_ok   = !any_prot && !whole_lock_bit_i;
    wire       erase_ok  = standby && latch_r;
    wire       go_addr   = cs_rise && is_addr_er && f_addr && erase_ok &&
                           !blk_prot;
    wire       go_chip   = cs_rise && is_chip_er && f_op8 && erase_ok &&
                           chip_ok;
    wire       go_sleep  = cs_rise && op_r == sfe_pkg::OP_SLEEP && f_op8 &&
                           standby;
    wire       wake_cmd  = cs_rise && op_r == sfe_pkg::OP_WAKE_ID &&
                           bits_r >= sfe_pkg::BITS_OPCODE;
    wire       go_wake   = wake_cmd && asleep;
    wire       go_reset  = cs_rise && op_r == sfe_pkg::OP_SOFT_RESET &&
                           f_op8 && (asleep || standby);
    wire       wen_cmd   = cs_rise && op_r == sfe_pkg::OP_WRITE_EN && f_op8 &&
                           standby;

    // shift opcode then address, msb first on rising serial edges
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            bits_r <= 6'h00;
            op_r   <= 8'h00;
            addr_r <= '0;
        end else if (cs_n) begin
            bits_r <= 6'h00;
        end else if (rise) begin
            if (bits_r != 6'h3F) begin
                bits_r <= bits_r + 6'h01;
            end
            if (bits_r < sfe_pkg::BITS_OPCODE) begin
                op_r <= op_now;
            end else if (bits_r < sfe_pkg::BITS_ADDR_CMD) begin
                addr_r <= {addr_r[ADDR_LEN-2:0], din};
            end
        end
    end

    // state and self-timed delays
    always_comb begin
        st_nxt  = st_r;
        tmr_nxt = (tmr_r != '0) ? tmr_r - 1'b1 : tmr_r;
        req_nxt = req_r;
        req_nxt.start = 1'b0;
        case (st_r)
            sfe_pkg::SFE_STANDBY: begin
                if (go_addr) begin
                    st_nxt = sfe_pkg::SFE_BUSY;
                    req_nxt.start = 1'b1;
                    req_nxt.addr  = addr_r;
                    req_nxt.kind  = (op_r == sfe_pkg::OP_HALF_ERASE) ?
                                    sfe_pkg::SFE_ER_HALF :
                                    sfe_pkg::SFE_ER_BLOCK;
                end else if (go_chip) begin
                    st_nxt = sfe_pkg::SFE_BUSY;
                    req_nxt.start = 1'b1;
                    req_nxt.addr  = '0;
                    req_nxt.kind  = sfe_pkg::SFE_ER_CHIP;
                end else if (go_sleep) begin
                    st_nxt  = sfe_pkg::SFE_ENTERING;
                    tmr_nxt = sfe_pkg::TIMER_W'(sfe_pkg::SLEEP_ENTRY_CYC);
                end
            end
            sfe_pkg::SFE_BUSY: begin
                if (erase_done_i) begin
                    st_nxt = sfe_pkg::SFE_STANDBY;
                end
            end
            sfe_pkg::SFE_ENTERING: begin
                if (tmr_r == '0) begin
                    st_nxt = sfe_pkg::SFE_ASLEEP;
                end
            end
            sfe_pkg::SFE_ASLEEP: begin
                if (go_wake) begin
                    st_nxt  = sfe_pkg::SFE_WAKING;
                    tmr_nxt = sfe_pkg::TIMER_W'(sfe_pkg::WAKE_LONG_CYC);
                end else if (go_reset) begin
                    st_nxt = sfe_pkg::SFE_STANDBY;
                end
            end
            sfe_pkg::SFE_WAKING: begin
                if (tmr_r == '0) begin
                    st_nxt = sfe_pkg::SFE_STANDBY;
                end
            end
            default: st_nxt = sfe_pkg::SFE_STANDBY;
        endcase
    end

    // power-up and reset always land in standby
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            st_r  <= sfe_pkg::SFE_STANDBY;
            tmr_r <= '0;
            req_r <= '0;
        end else begin
            st_r  <= st_nxt;
            tmr_r <= tmr_nxt;
            req_r <= req_nxt;
        end
    end

    // write latch: set by write-enable, dropped once erase is launched
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            latch_r <= 1'b0;
        end else if (wen_cmd) begin
            latch_r <= 1'b1;
        end else if (go_addr || go_chip || go_reset) begin
            latch_r <= 1'b0;
        end
    end

    // output shifter: ID for wake/ID after the dummies, status on 05h;
    // driven on falling serial edges; ID never while busy, status also while busy
    wire load_id = fall && (standby || st_r == sfe_pkg::SFE_WAKING) &&
                   op_r == sfe_pkg::OP_WAKE_ID &&
                   bits_r >= sfe_pkg::BITS_ID_CMD && out_cnt_r == 3'h0;
    wire load_st = fall && op_r == sfe_pkg::OP_READ_STATUS && !asleep &&
                   bits_r >= sfe_pkg::BITS_OPCODE && out_cnt_r == 3'h0;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            out_r     <= 8'h00;
            out_cnt_r <= 3'h0;
            oe_r      <= 1'b0;
        end else if (cs_n) begin
            out_cnt_r <= 3'h0;
            oe_r      <= 1'b0;
        end else if (load_id) begin
            out_r     <= DEVICE_ID;
            out_cnt_r <= 3'h7;
            oe_r      <= 1'b1;
        end else if (load_st) begin
            out_r     <= {6'h00, latch_r, !standby &&
                          st_r == sfe_pkg::SFE_BUSY};
            out_cnt_r <= 3'h7;
            oe_r      <= 1'b1;
        end else if (fall && oe_r) begin
            out_r     <= {out_r[6:0], 1'b0};
            out_cnt_r <= out_cnt_r - 3'h1;
        end
    end

    assign serial_out_o       = out_r[7];
    assign serial_out_oe_o    = oe_r;
    assign erase_req_o        = req_r;
    assign busy_flag_o        = st_r == sfe_pkg::SFE_BUSY;
    assign write_latch_flag_o = latch_r;
    // waking still reports deep power-down until the long delay ends
    assign asleep_o           = asleep || st_r == sfe_pkg::SFE_WAKING;

    // helper: cycles spent entering sleep, so the entry delay can be
    // checked without a long repetition
    logic [sfe_pkg::TIMER_W-1:0] ent_cnt_r;
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            ent_cnt_r <= '0;
        end else if (st_r == sfe_pkg::SFE_ENTERING) begin
            ent_cnt_r <= ent_cnt_r + 1'b1;
        end else begin
            ent_cnt_r <= '0;
        end
    end

    // erase launch: latch, framing, protection and timing
    AST_BUSY_HOLD: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        st_r == sfe_pkg::SFE_BUSY && !erase_done_i |=> busy_flag_o)
        else $error("busy dropped without erase done");
    AST_ERASE_NEEDS_LATCH: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        req_r.start |-> $past(latch_r))
        else $error("erase launched without write latch");
    AST_LATCH_CLEARED: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        req_r.start |-> !latch_r && busy_flag_o)
        else $error("latch still set after erase launch");
    AST_CHIP_PROT: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        req_r.start && req_r.kind == sfe_pkg::SFE_ER_CHIP |->
        $past(protect_level_bits_i) == 4'h0 && !$past(whole_lock_bit_i))
        else $error("chip erase with protection set");
    AST_START_ON_RISE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        req_r.start |-> $past(cs_rise))
        else $error("erase not started by select rise");
    AST_START_PULSE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        req_r.start |=> !req_r.start)
        else $error("erase request longer than one cycle");
    AST_ADDR_FRAME: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        req_r.start && req_r.kind != sfe_pkg::SFE_ER_CHIP |->
        $past(bits_r) == sfe_pkg::BITS_ADDR_CMD)
        else $error("address erase with wrong bit count");
    AST_CHIP_FRAME: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        req_r.start && req_r.kind == sfe_pkg::SFE_ER_CHIP |->
        $past(bits_r) == sfe_pkg::BITS_OPCODE)
        else $error("chip erase with wrong bit count");
    AST_BLOCK_PROT: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        req_r.start && req_r.kind != sfe_pkg::SFE_ER_CHIP |->
        !$past(blk_prot))
        else $error("erase of a protected block");

    // sleep entry and exit
    AST_SLEEP_DELAY: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        st_r == sfe_pkg::SFE_STANDBY && go_sleep |=> !asleep [*8])
        else $error("sleep entered without delay");
    AST_ENTRY_TIME: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        $rose(asleep) |->
        ent_cnt_r >= sfe_pkg::TIMER_W'(sfe_pkg::SLEEP_ENTRY_CYC))
        else $error("sleep entered before the entry delay");
    AST_SLEEP_NO_ERASE: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        asleep |=> !req_r.start)
        else $error("erase while asleep");
    AST_SLEEP_BUSY: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        busy_flag_o && !erase_done_i |=> st_r != sfe_pkg::SFE_ENTERING)
        else $error("sleep accepted while busy");
    AST_WAKE_FROM_SLEEP: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        $rose(st_r == sfe_pkg::SFE_WAKING) |-> $past(asleep))
        else $error("wake delay started outside sleep");
    AST_WAKE_EXIT: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        st_r == sfe_pkg::SFE_WAKING |-> ##[1:80] standby)
        else $error("wake did not end in standby");

    // data out only inside a frame, and no ID while busy
    AST_OE_IN_FRAME: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        cs_n && $past(cs_n) |-> !serial_out_oe_o)
        else $error("data out driven while deselected");
    AST_NO_ID_BUSY: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        busy_flag_o |-> !load_id)
        else $error("device ID loaded while busy");

    COV_HALF: cover property (@(posedge clk_i)
        req_r.start && req_r.kind == sfe_pkg::SFE_ER_HALF);
    COV_CHIP: cover property (@(posedge clk_i)
        req_r.start && req_r.kind == sfe_pkg::SFE_ER_CHIP);
    COV_SLEEP: cover property (@(posedge clk_i) asleep);
    COV_ID: cover property (@(posedge clk_i) load_id);
    COV_WAKE: cover property (@(posedge clk_i)
        st_r == sfe_pkg::SFE_WAKING);
endmodule
`default_nettype wire

// File: rtl/sfe_pkg.sv
// Purpose: constants and types for the serial flash erase and power-down
//          controller.
// Assumes: 40 MHz system clock; the serial link is sampled, not clocked.
// Notes:   opcodes, address layout, delays and status bit positions.
package sfe_pkg;
    localparam logic [7:0] OP_HALF_ERASE  = 8'h52;
    localparam logic [7:0] OP_BLOCK_ERASE = 8'hD8;
    localparam logic [7:0] OP_CHIP_ERASE1 = 8'hC7;
    localparam logic [7:0] OP_CHIP_ERASE2 = 8'h60;
    localparam logic [7:0] OP_SLEEP       = 8'hB9;
    localparam logic [7:0] OP_WAKE_ID     = 8'hAB;
    localparam logic [7:0] OP_WRITE_EN    = 8'h06;
    localparam logic [7:0] OP_READ_STATUS = 8'h05;
    localparam logic [7:0] OP_SOFT_RESET  = 8'h99;

    localparam logic [5:0] BITS_OPCODE    = 6'h08;
    localparam logic [5:0] BITS_ADDR_CMD  = 6'h20;
    localparam logic [5:0] BITS_ID_CMD    = 6'h20;

    // 24-bit address: a23..a16 pick the 64K block, a15 the half
    localparam int ADDR_W      = 24;
    localparam int BLK_MSB     = 23;
    localparam int BLK_LSB     = 16;
    localparam int HALF_BIT    = 15;
    localparam int STAT_BUSY   = 0;
    localparam int STAT_LATCH  = 1;

    // delays in ns, converted to 40 MHz cycles
    localparam int CLK_NS         = 25;
    localparam int SLEEP_ENTRY_NS = 3000;
    localparam int WAKE_SHORT_NS  = 3000;
    localparam int WAKE_LONG_NS   = 1800;
    localparam int SLEEP_ENTRY_CYC = (SLEEP_ENTRY_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_SHORT_CYC  = (WAKE_SHORT_NS + CLK_NS - 1) / CLK_NS;
    localparam int WAKE_LONG_CYC   = (WAKE_LONG_NS + CLK_NS - 1) / CLK_NS;
    localparam int TIMER_W         = 16;

    typedef enum logic [2:0] {
        SFE_STANDBY  = 3'b000,
        SFE_BUSY     = 3'b001,
        SFE_ENTERING = 3'b010,
        SFE_ASLEEP   = 3'b011,
        SFE_WAKING   = 3'b100
    } sfe_state_t;

    typedef enum logic [1:0] {
        SFE_ER_HALF  = 2'b00,
        SFE_ER_BLOCK = 2'b01,
        SFE_ER_CHIP  = 2'b10
    } sfe_erase_t;

    // erase request to the array
    typedef struct packed {
        logic              start;
        sfe_erase_t        kind;
        logic [ADDR_W-1:0] addr;
    } sfe_erase_req_t;
endpackage

// File: rtl/sfe_pin_sync.sv
// Purpose: two-flop synchroniser and edge finder for the serial pins.
// Assumes: pins are asynchronous to clk_i.
// Notes:   the first flop feeds only the second flop.
`timescale 1ns/1ps
`default_nettype none
module sfe_pin_sync (
    input  wire logic clk_i,       // system clock
    input  wire logic sys_rst_i,   // async reset, active high
    input  wire logic sck_i,       // serial clock pin
    input  wire logic cs_n_i,      // select pin, active low
    input  wire logic serial_in_i, // data pin
    output logic      rise_o,      // serial clock rising, one cycle
    output logic      fall_o,      // serial clock falling, one cycle
    output logic      cs_n_o,      // synchronised select
    output logic      cs_rise_o,   // select deasserted, one cycle
    output logic      din_o        // synchronised data
);
    logic [2:0] m1_r;
    logic [2:0] m2_r;
    logic [1:0] old_r;

    // double flop, then one history stage for edges
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            m1_r  <= 3'h7;
            m2_r  <= 3'h7;
            old_r <= 2'h3;
        end else begin
            m1_r  <= {cs_n_i, sck_i, serial_in_i};
            m2_r  <= m1_r;
            old_r <= m2_r[2:1];
        end
    end

    // gate edges with select so no stray clock counts outside a frame
    assign rise_o    = m2_r[1] & ~old_r[0] & ~m2_r[2];
    assign fall_o    = ~m2_r[1] & old_r[0] & ~m2_r[2];
    assign cs_n_o    = m2_r[2];
    assign cs_rise_o = m2_r[2] & ~old_r[1];
    assign din_o     = m2_r[0];
endmodule
`default_nettype wire

// File: verification/sfe_host_model.sv
// Purpose: host controller model that frames commands on the serial pins.
// Assumes: mode 0 framing, serial clock period of eight system clocks.
// Notes:   clock rests low between frames; data line flips when released.
`timescale 1ns/1ps
`default_nettype none
module sfe_host_model (
    input  wire logic clk_i,        // system clock, pacing only
    input  wire logic serial_out_i, // device data out
    output var logic  sck_o,        // serial clock to device
    output var logic  cs_n_o,       // select, active low
    output var logic  serial_in_o   // data to device
);
    initial begin
        sck_o = 1'b0;
        cs_n_o = 1'b1;
        serial_in_o = 1'b0;
    end

    // select held low for the whole frame, bits msb first, data set
    // while clock is low and held past the rising edge
    task automatic frame(input logic [31:0] tx, input int n,
                         input int nrd, output logic [15:0] rx);
        int i;
        rx = 16'h0000;
        repeat (8) @(negedge clk_i);
        cs_n_o = 1'b0;
        for (i = 0; i < n + nrd; i++) begin
            serial_in_o = (i < n) ? tx[31-i] : ~serial_in_o;
            repeat (4) @(negedge clk_i);
            sck_o = 1'b1;
            if (i >= n) rx = {rx[14:0], serial_out_i};
            repeat (4) @(negedge clk_i);
            sck_o = 1'b0;
        end
        repeat (4) @(negedge clk_i);
        cs_n_o = 1'b1;
        // released line shows the inverse, never a stale value
        serial_in_o = ~serial_in_o;
    endtask
endmodule
`default_nettype wire

// File: verification/serial_flash_erase_powerdown_ctrl_tb.sv
// Purpose: self-checking bench for the erase and power-down controller.
// Assumes: inputs change on falling clock edges; array done is a pulse.
// Notes:   erase requests are queued and matched by a monitor process.
`timescale 1ns/1ps
`default_nettype none
module serial_flash_erase_powerdown_ctrl_tb;
    localparam logic [7:0] ID_VAL = 8'hC3; // arbitrary value
    logic                   clk_i;
    logic                   sys_rst_i;
    logic                   erase_done_i;
    logic                   whole_lock_bit_i;
    logic                   boot_lock_i;
    logic [3:0]             protect_level_bits_i;
    logic [7:0]             boot_block_i;
    logic                   sck;
    logic                   cs_n;
    logic                   sdi;
    logic                   sdo;
    logic                   sdo_oe;
    logic                   busy;
    logic                   latch;
    logic                   asleep;
    sfe_pkg::sfe_erase_req_t req;
    sfe_pkg::sfe_erase_req_t e_m;
    sfe_pkg::sfe_erase_req_t exp_q[$];
    int                     n_mismatch;
    int                     comparisons;
    int                     i;
    logic [31:0]            rnd;
    logic [15:0]            rx;

    // a released data line reads as the inverse of its last value
    sfe_host_model host (.clk_i(clk_i), .serial_out_i(sdo_oe ? sdo : ~sdo),
                         .sck_o(sck), .cs_n_o(cs_n), .serial_in_o(sdi));

    sfe_ctrl #(.DEVICE_ID(ID_VAL)) DUT (
        .clk_i(clk_i), .sys_rst_i(sys_rst_i), .sck_i(sck), .cs_n_i(cs_n),
        .serial_in_i(sdi), .serial_out_o(sdo), .serial_out_oe_o(sdo_oe),
        .protect_level_bits_i(protect_level_bits_i),
        .whole_lock_bit_i(whole_lock_bit_i), .boot_lock_i(boot_lock_i),
        .boot_block_i(boot_block_i), .erase_done_i(erase_done_i),
        .erase_req_o(req), .busy_flag_o(busy),
        .write_latch_flag_o(latch), .asleep_o(asleep));

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic summarize();
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic cmd(input logic [31:0] tx, input int n);
        host.frame(tx, n, 0, rx);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(negedge clk_i);
    endtask

    // write enable, then erase; a refused erase must leave busy low
    task automatic erase(input logic [7:0] op, input sfe_pkg::sfe_erase_t k,
                         input logic [23:0] a, input int n, input logic ok);
        cmd({sfe_pkg::OP_WRITE_EN, 24'h000000}, 8);
        wait_clk(6);
        check(latch, 1);
        if (ok) exp_q.push_back('{start: 1'b1, kind: k, addr: a});
        cmd({op, a}, n);
        wait_clk(6);
        check(busy, ok);
        if (ok) begin
            check(latch, 0);
            wait_clk(20);
            check(busy, 1);
            erase_done_i = 1'b1;
            wait_clk(1);
            erase_done_i = 1'b0;
            wait_clk(4);
            check(busy, 0);
        end
    endtask

    // clock generator, 25 ns period
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // every start pulse must match the oldest queued request
    always @(posedge clk_i) begin
        if (req.start === 1'b1) begin
            if (exp_q.size() == 0) begin
                check(1, 0);
            end else begin
                e_m = exp_q.pop_front();
                check(req.kind, e_m.kind);
                if (e_m.kind != sfe_pkg::SFE_ER_CHIP)
                    check(req.addr, e_m.addr);
            end
        end
    end

    // watchdog well beyond the expected run length
    initial begin
        repeat (60000) @(posedge clk_i);
        n_mismatch++;
        summarize();
    end

    initial begin
        sys_rst_i = 1'b1;
        erase_done_i = 1'b0;
        whole_lock_bit_i = 1'b0;
        boot_lock_i = 1'b0;
        protect_level_bits_i = 4'h0;
        boot_block_i = 8'hFF;
        n_mismatch = 0;
        comparisons = 0;
        rnd = 32'h00000041;
        wait_clk(20);
        sys_rst_i = 1'b0;
        wait_clk(4);
        check({busy, latch, asleep, sdo_oe}, 0);
        // erase without a prior write enable is refused
        cmd({sfe_pkg::OP_HALF_ERASE, 24'h001234}, 32);
        wait_clk(6);
        check(busy, 0);
        for (i = 0; i < 4; i++) begin
            rnd = xs(rnd);
            erase(i[0] ? sfe_pkg::OP_BLOCK_ERASE : sfe_pkg::OP_HALF_ERASE,
                  i[0] ? sfe_pkg::SFE_ER_BLOCK : sfe_pkg::SFE_ER_HALF,
                  {1'b0, rnd[22:0]}, 32, 1'b1);
        end
        erase(sfe_pkg::OP_CHIP_ERASE1, sfe_pkg::SFE_ER_CHIP, 0, 8, 1);
        erase(sfe_pkg::OP_CHIP_ERASE2, sfe_pkg::SFE_ER_CHIP, 0, 8, 1);
        erase(sfe_pkg::OP_HALF_ERASE, sfe_pkg::SFE_ER_HALF, 24'h000100, 31, 0);
        erase(sfe_pkg::OP_CHIP_ERASE1, sfe_pkg::SFE_ER_CHIP, 0, 9, 0);
        protect_level_bits_i = 4'h2;
        erase(sfe_pkg::OP_BLOCK_ERASE, sfe_pkg::SFE_ER_BLOCK, 24'hFD0000, 32, 0);
        erase(sfe_pkg::OP_HALF_ERASE, sfe_pkg::SFE_ER_HALF, 24'h208000, 32, 1);
        erase(sfe_pkg::OP_CHIP_ERASE1, sfe_pkg::SFE_ER_CHIP, 0, 8, 0);
        protect_level_bits_i = 4'h0;
        whole_lock_bit_i = 1'b1;
        erase(sfe_pkg::OP_CHIP_ERASE2, sfe_pkg::SFE_ER_CHIP, 0, 8, 0);
        whole_lock_bit_i = 1'b0;
        boot_lock_i = 1'b1;
        boot_block_i = 8'h10;
        erase(sfe_pkg::OP_HALF_ERASE, sfe_pkg::SFE_ER_HALF, 24'h108000, 32, 0);
        boot_lock_i = 1'b0;
        // sleep and wake/ID sent while an erase is running
        cmd({sfe_pkg::OP_WRITE_EN, 24'h000000}, 8);
        exp_q.push_back('{start: 1'b1, kind: sfe_pkg::SFE_ER_BLOCK, addr: 24'h030000});
        cmd({sfe_pkg::OP_BLOCK_ERASE, 24'h030000}, 32);
        cmd({sfe_pkg::OP_SLEEP, 24'h000000}, 8);
        wait_clk(135);
        check(asleep, 0);
        host.frame({sfe_pkg::OP_WAKE_ID, 24'h000000}, 32, 16, rx);
        check(rx == {ID_VAL, ID_VAL}, 0);
        check(busy, 1);
        host.frame({sfe_pkg::OP_READ_STATUS, 24'h000000}, 8, 8, rx);
        check(rx[7:0], 8'h01);
        erase_done_i = 1'b1;
        wait_clk(1);
        erase_done_i = 1'b0;
        wait_clk(4);
        check(busy, 0);
        // sleep frame with a wrong bit count is not executed
        cmd({sfe_pkg::OP_SLEEP, 24'h000000}, 9);
        wait_clk(135);
        check(asleep, 0);
        cmd({sfe_pkg::OP_SLEEP, 24'h000000}, 8);
        wait_clk(100);
        check(asleep, 0);
        wait_clk(35);
        check(asleep, 1);
        cmd({sfe_pkg::OP_WRITE_EN, 24'h000000}, 8);
        cmd({sfe_pkg::OP_HALF_ERASE, 24'h000000}, 32);
        wait_clk(6);
        check({busy, latch, asleep}, 1);
        cmd({sfe_pkg::OP_WAKE_ID, 24'h000000}, 8);
        wait_clk(60);
        check(asleep, 1);
        wait_clk(25);
        check(asleep, 0);
        host.frame({sfe_pkg::OP_WAKE_ID, 24'h000000}, 32, 16, rx);
        check(rx, {ID_VAL, ID_VAL});
        cmd({sfe_pkg::OP_SLEEP, 24'h000000}, 8);
        wait_clk(135);
        cmd({sfe_pkg::OP_SOFT_RESET, 24'h000000}, 8);
        wait_clk(100);
        check(asleep, 0);
        // reset in mid-run while asleep with the latch set
        cmd({sfe_pkg::OP_WRITE_EN, 24'h000000}, 8);
        host.frame({sfe_pkg::OP_READ_STATUS, 24'h000000}, 8, 8, rx);
        check(rx[7:0], 8'h02);
        cmd({sfe_pkg::OP_SLEEP, 24'h000000}, 8);
        wait_clk(135);
        sys_rst_i = 1'b1;
        wait_clk(2);
        sys_rst_i = 1'b0;
        wait_clk(4);
        check({busy, latch, asleep}, 0);
        check(exp_q.size(), 0);
        summarize();
    end
endmodule
`default_nettype wire
